// *** inc/hcpd_pkg.sv ***
package hcpd_pkg;

  // ********************************************
  // Command codes and packet layout
  // ********************************************
  localparam logic [15:0] CMD_RANGE = 16'h000e;    // Range-change command code.
  localparam logic [15:0] CMD_FMT = 16'h0015;      // Timestamp-format command code.
  localparam logic [15:0] LEN_SHORT = 16'h0004;    // Length of both short commands.
  localparam logic [15:0] PWR_LO = 16'h0100;       // First parameter-write identifier.
  localparam logic [15:0] PWR_HI = 16'h0fff;       // Last parameter-write identifier.
  localparam logic [15:0] PRD_LO = 16'h1000;       // First parameter-read identifier.
  localparam logic [15:0] PRD_HI = 16'h1fff;       // Last parameter-read identifier.
  localparam int HDR_BYTES = 4;                    // Identifier plus length bytes.
  localparam int PKT_MAX = 16;                     // Largest packet the decoder holds.

  // ********************************************
  // Parameter groups and system parameters
  // ********************************************
  localparam logic [11:0] GRP_SYS_LO = 12'h100;    // System group start.
  localparam logic [11:0] GRP_SYS_HI = 12'h1ff;    // System group end.
  localparam logic [11:0] GRP_ALG_LO = 12'h200;    // Fusion algorithm group start.
  localparam logic [11:0] GRP_ALG_HI = 12'h2ff;    // Fusion algorithm group end.
  localparam logic [11:0] GRP_VSI_LO = 12'h300;    // Virtual sensor information start.
  localparam logic [11:0] GRP_VSI_HI = 12'h3ff;    // Virtual sensor information end.
  localparam logic [11:0] GRP_VSC_LO = 12'h500;    // Virtual sensor configuration start.
  localparam logic [11:0] GRP_VSC_HI = 12'h5ff;    // Virtual sensor configuration end.
  localparam logic [11:0] GRP_CUS_LO = 12'h800;    // Customer group start.
  localparam logic [11:0] GRP_CUS_HI = 12'hdff;    // Customer group end.
  localparam logic [11:0] GRP_PSC_LO = 12'he00;    // Physical sensor control start.
  localparam logic [11:0] GRP_PSC_HI = 12'heff;    // Physical sensor control end.
  localparam logic [11:0] SYS_RW_LO = 12'h101;     // First read/write system parameter.
  localparam logic [11:0] SYS_RW_HI = 12'h103;     // Last of the first read/write run.
  localparam logic [11:0] SYS_RO_LO = 12'h104;     // First read-only system parameter.
  localparam logic [11:0] SYS_RO_HI = 12'h106;     // Last of the read-only run.
  localparam logic [11:0] SYS_VPRES = 12'h11f;     // Virtual sensors present, read-only.
  localparam logic [11:0] SYS_PPRES = 12'h120;     // Physical sensors present, read-only.
  localparam logic [11:0] SYS_PSI_LO = 12'h121;    // Physical sensor information start.
  localparam logic [11:0] SYS_PSI_HI = 12'h160;    // Physical sensor information end.

  // ********************************************
  // Group codes reported with each decode
  // ********************************************
  typedef enum logic [2:0] {
    HCPD_GRP_RSV = 3'h0,
    HCPD_GRP_SYS = 3'h1,
    HCPD_GRP_ALG = 3'h2,
    HCPD_GRP_VSI = 3'h3,
    HCPD_GRP_VSC = 3'h4,
    HCPD_GRP_CUS = 3'h5,
    HCPD_GRP_PSC = 3'h6
  } hcpd_grp_t;

  // ********************************************
  // Sensors, ranges and scaling
  // ********************************************
  localparam int NUM_VS = 8;                       // Virtual sensors tracked.
  localparam int NUM_PS = 4;                       // Physical sensors behind them.
  localparam logic [2:0] PS_FUSED = 3'h7;          // Map code for a multi-sensor output.
  // Virtual-to-physical map, three bits per virtual sensor, sensor 0 in the low bits.
  localparam logic [23:0] VS_MAP_RST = 24'hfda240;
  localparam logic [15:0] RANGE_DEF = 16'h0008;    // Default range of each physical sensor.
  localparam logic [4:0] SAMPLE_BITS = 5'h10;      // Output sample width.
  localparam logic SAMPLE_SIGNED = 1'b1;           // Samples are signed.
  localparam logic [1:0] FMT_RST = 2'h0;           // Format flags after reset.

  // ********************************************
  // Controller register offsets (APB)
  // ********************************************
  localparam logic [7:0] REG_CTRL = 8'h00;         // Bit 0 start, write-only pulse.
  localparam logic [7:0] REG_ID = 8'h04;           // Command identifier in bits 15:0.
  localparam logic [7:0] REG_PAY0 = 8'h08;         // Payload bytes 4..7, byte 4 lowest.
  localparam logic [7:0] REG_PAY1 = 8'h0c;         // Payload bytes 8..11.
  localparam logic [7:0] REG_LEN = 8'h10;          // Length field in bits 15:0.
  localparam logic [7:0] REG_STAT = 8'h14;         // Busy in bit 0, response count in bits 4:1.
  localparam logic [7:0] REG_RSP0 = 8'h18;         // Response bytes 0..3.
  localparam logic [7:0] REG_RSP1 = 8'h1c;         // Response bytes 4..7.

  // Scale exponent: range times full scale over code span, kept as a shift count.
  function automatic logic [4:0] hcpd_scale(input logic [15:0] rng, input logic [4:0] bits, input logic sgn);
    logic [4:0] msb;
    msb = 5'h0;
    for (int i = 0; i < 16; i++) begin
      if (rng[i]) begin
        msb = 5'(i);
      end
    end
    hcpd_scale = 5'(bits - 5'(sgn) - msb);
  endfunction

  // Scale exponent of the default range, shown by every sensor after reset.
  localparam logic [4:0] SCALE_RST = hcpd_scale(RANGE_DEF, SAMPLE_BITS, SAMPLE_SIGNED);

endpackage

// *** inc/hcpd_if.sv ***
`timescale 1ns/1ns
// Byte link between host and decoder: host writes channel 0, device answers on channel 3.
interface hcpd_if;
  logic [7:0] ch0_data;   // Input channel 0 byte.
  logic ch0_valid;        // Byte is offered.
  logic ch0_last;         // Final byte of the packet.
  logic ch0_ready;        // Decoder takes the byte.
  logic [7:0] ch3_data;   // Output channel 3 byte.
  logic ch3_valid;        // Response byte offered.
  logic ch3_last;         // Final response byte.
  logic ch3_ready;        // Host takes the response byte.

  modport dev (input ch0_data, input ch0_valid, input ch0_last, output ch0_ready,
               output ch3_data, output ch3_valid, output ch3_last, input ch3_ready);
  modport host (output ch0_data, output ch0_valid, output ch0_last, input ch0_ready,
                input ch3_data, input ch3_valid, input ch3_last, output ch3_ready);
endinterface

// *** rtl/hcpd_classify.sv ***
`timescale 1ns/1ns
// Combinational classifier for a command identifier.
module hcpd_classify
  import hcpd_pkg::*;
(
  // Identifier under test.
  input wire logic [15:0] cmd_id,
  // Decode results.
  output logic is_range,
  output logic is_fmt,
  output logic is_param,
  output logic is_read,
  output hcpd_grp_t grp,
  output logic allowed
);

  wire logic [11:0] pnum;
  wire logic in_w;
  wire logic in_r;
  wire logic sys_ro;
  wire logic sys_rw;

  assign pnum = cmd_id[11:0];
  assign is_range = (cmd_id == CMD_RANGE);
  assign is_fmt = (cmd_id == CMD_FMT);
  assign in_w = (cmd_id >= PWR_LO) && (cmd_id <= PWR_HI);
  assign in_r = (cmd_id >= PRD_LO) && (cmd_id <= PRD_HI);
  assign is_param = in_w || in_r;
  assign is_read = (cmd_id[15:12] == 4'h1);

  // Group routing by parameter number.
  always_comb begin
    if (pnum >= GRP_SYS_LO && pnum <= GRP_SYS_HI) begin
      grp = HCPD_GRP_SYS;
    end else if (pnum >= GRP_ALG_LO && pnum <= GRP_ALG_HI) begin
      grp = HCPD_GRP_ALG;
    end else if (pnum >= GRP_VSI_LO && pnum <= GRP_VSI_HI) begin
      grp = HCPD_GRP_VSI;
    end else if (pnum >= GRP_VSC_LO && pnum <= GRP_VSC_HI) begin
      grp = HCPD_GRP_VSC;
    end else if (pnum >= GRP_CUS_LO && pnum <= GRP_CUS_HI) begin
      grp = HCPD_GRP_CUS;
    end else if (pnum >= GRP_PSC_LO && pnum <= GRP_PSC_HI) begin
      grp = HCPD_GRP_PSC;
    end else begin
      grp = HCPD_GRP_RSV;
    end
  end

  // Access rights inside the system group; unlisted system numbers are reserved.
  assign sys_rw = (pnum >= SYS_RW_LO && pnum <= SYS_RW_HI) || (pnum >= SYS_PSI_LO && pnum <= SYS_PSI_HI);
  assign sys_ro = (pnum >= SYS_RO_LO && pnum <= SYS_RO_HI) || pnum == SYS_VPRES || pnum == SYS_PPRES;
  assign allowed = is_param && (grp != HCPD_GRP_RSV) &&
                   ((grp != HCPD_GRP_SYS) || sys_rw || (sys_ro && is_read));

endmodule

// *** rtl/hcpd_dev.sv ***
`timescale 1ns/1ns
// Function
// - Range command: id 0x000E, sensor, range
// - Refuse range change on fused sensors
// - Host targets single-sensor outputs only
// - Zero range selects physical default range
// - Physical range is largest nonzero request
// - Scale factor follows range, width, sign
// - Host watches range-changed event
// - Format command: id 0x0015, flags byte
// - Flags zero: delta and full timestamps
// - Flags 0x01: drop delta timestamps
// - Flags 0x02: drop header timestamp
// - Flags 0x03: drop both timestamps
// - Classify parameter write and read ranges
// - Top hex digit selects read/write
// - Whole parameter, one direction per transaction; reads are answered with a zero-length header only
// - Host reads with id 0x1 plus number
// - Read response goes to channel 3
// - Host writes the whole parameter structure
// - Route parameter numbers by group
// - System parameter read/write versus read-only
module hcpd_dev
  import hcpd_pkg::*;
(
  // Clock, reset and enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // Link to the host.
  hcpd_if.dev lnk,
  // Timestamp controls to the FIFO writer.
  output logic ts_delta_en,
  output logic ts_full_en,
  // Physical sensor ranges and scale exponents, sensor 0 in the low bits.
  output logic [NUM_PS*16-1:0] ps_range,
  output logic [NUM_PS*5-1:0] ps_scale,
  // Per-command outcome.
  output logic cmd_done,
  output logic cmd_reject,
  output logic range_changed,
  // Parameter write handed on, with its group and number.
  output logic pwr_valid,
  output logic [2:0] pwr_group,
  output logic [11:0] pwr_num
);

  // ****************************************************
  // State
  // ****************************************************
  typedef enum logic [2:0] {
    HCPD_ST_RX = 3'b001,
    HCPD_ST_EXEC = 3'b010,
    HCPD_ST_TX = 3'b100
  } hcpd_st_t;

  hcpd_st_t st_r;                        // Receive, execute, respond.
  logic [7:0] pkt_r [PKT_MAX];           // Packet bytes as received.
  logic [4:0] cnt_r;                     // Bytes received or sent.
  logic [15:0] req_r [NUM_VS];           // Range requested per virtual sensor.
  logic [1:0] fmt_r;                     // Timestamp flags.
  logic [7:0] rsp_r [HDR_BYTES];         // Response header bytes.

  wire logic [15:0] cmd_id;
  wire logic [15:0] len;
  wire logic [7:0] sid;
  wire logic [15:0] rng;
  wire logic is_range;
  wire logic is_fmt;
  wire logic is_param;
  wire logic is_read;
  wire logic allowed;
  hcpd_grp_t grp;
  wire logic [2:0] sid_ps;
  wire logic range_ok;
  wire logic take;
  wire logic give;
  logic [NUM_PS*16-1:0] range_nxt;       // Selected range per physical sensor.
  logic [NUM_PS*5-1:0] scale_nxt;        // Scale exponent per physical sensor.

  assign cmd_id = {pkt_r[1], pkt_r[0]};
  assign len = {pkt_r[3], pkt_r[2]};
  assign sid = pkt_r[4];
  assign rng = {pkt_r[6], pkt_r[5]};
  assign sid_ps = VS_MAP_RST[3*sid[2:0] +: 3];
  // Byte 7 of both short commands and upper flag bits are never read.
  assign range_ok = is_range && (sid < 8'(NUM_VS)) && (sid_ps != PS_FUSED) && (len == LEN_SHORT);
  assign take = (st_r == HCPD_ST_RX) && lnk.ch0_valid;
  assign give = (st_r == HCPD_ST_TX) && lnk.ch3_ready;
  assign lnk.ch0_ready = (st_r == HCPD_ST_RX);
  assign lnk.ch3_valid = (st_r == HCPD_ST_TX);
  assign lnk.ch3_data = rsp_r[cnt_r[1:0]];
  assign lnk.ch3_last = (cnt_r == 5'(HDR_BYTES - 1));

  hcpd_classify u_cls (
    .cmd_id(cmd_id),
    .is_range(is_range),
    .is_fmt(is_fmt),
    .is_param(is_param),
    .is_read(is_read),
    .grp(grp),
    .allowed(allowed)
  );

  // ****************************************************
  // Range selection per physical sensor
  // ****************************************************
  // Largest nonzero request among sharers, else the default.
  always_comb begin
    logic [15:0] best;
    best = 16'h0;
    for (int p = 0; p < NUM_PS; p++) begin
      best = 16'h0;
      for (int v = 0; v < NUM_VS; v++) begin
        if (VS_MAP_RST[3*v +: 3] == 3'(p) && req_r[v] > best) begin
          best = req_r[v];
        end
      end
      if (best == 16'h0) begin
        best = RANGE_DEF;
      end
      range_nxt[16*p +: 16] = best;
      scale_nxt[5*p +: 5] = hcpd_scale(best, SAMPLE_BITS, SAMPLE_SIGNED);
    end
  end

  // Output stage: timestamp enables and sensor ranges leave from flip-flops, one cycle after the state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts_delta_en <= ~FMT_RST[0];
      ts_full_en <= ~FMT_RST[1];
      ps_range <= {NUM_PS{RANGE_DEF}};
      ps_scale <= {NUM_PS{SCALE_RST}};
    end else if (clk_en) begin
      ts_delta_en <= ~fmt_r[0];
      ts_full_en <= ~fmt_r[1];
      ps_range <= range_nxt;
      ps_scale <= scale_nxt;
    end
  end

  // ****************************************************
  // Sequencer
  // ****************************************************
  // Collects one packet, acts on it once, answers reads with a header.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= HCPD_ST_RX;
      cnt_r <= 5'h0;
      fmt_r <= FMT_RST;
      cmd_done <= 1'b0;
      cmd_reject <= 1'b0;
      range_changed <= 1'b0;
      pwr_valid <= 1'b0;
      pwr_group <= 3'h0;
      pwr_num <= 12'h0;
      for (int i = 0; i < NUM_VS; i++) begin
        req_r[i] <= 16'h0;
      end
      for (int i = 0; i < PKT_MAX; i++) begin
        pkt_r[i] <= 8'h0;
      end
      for (int i = 0; i < HDR_BYTES; i++) begin
        rsp_r[i] <= 8'h0;
      end
    end else if (clk_en) begin
      cmd_done <= 1'b0;
      cmd_reject <= 1'b0;
      range_changed <= 1'b0;
      pwr_valid <= 1'b0;
      case (st_r)
        HCPD_ST_RX: begin
          if (take) begin
            // Bytes beyond the buffer are dropped; the packet still ends on last.
            if (cnt_r < 5'(PKT_MAX)) begin
              pkt_r[cnt_r[3:0]] <= lnk.ch0_data;
              cnt_r <= cnt_r + 5'h1;
            end
            if (lnk.ch0_last) begin
              st_r <= HCPD_ST_EXEC;
            end
          end
        end
        HCPD_ST_EXEC: begin
          cnt_r <= 5'h0;
          st_r <= HCPD_ST_RX;
          cmd_done <= 1'b1;
          if (range_ok) begin
            req_r[sid[2:0]] <= rng;
            range_changed <= 1'b1;
          end else if (is_fmt && len == LEN_SHORT) begin
            fmt_r <= pkt_r[4][1:0];
          end else if (allowed && is_read) begin
            // Reads carry only the identifier; answer with its header.
            rsp_r[0] <= pkt_r[0];
            rsp_r[1] <= {4'h0, pkt_r[1][3:0]};
            rsp_r[2] <= 8'h0;
            rsp_r[3] <= 8'h0;
            st_r <= HCPD_ST_TX;
          end else if (allowed && !is_read) begin
            pwr_valid <= 1'b1;
            pwr_group <= grp;
            pwr_num <= cmd_id[11:0];
          end else begin
            cmd_reject <= 1'b1;
          end
        end
        HCPD_ST_TX: begin
          if (give) begin
            if (lnk.ch3_last) begin
              cnt_r <= 5'h0;
              st_r <= HCPD_ST_RX;
            end else begin
              cnt_r <= cnt_r + 5'h1;
            end
          end
        end
        default: begin
          st_r <= HCPD_ST_RX;
        end
      endcase
    end
  end

endmodule

// *** rtl/hcpd_host.sv ***
`timescale 1ns/1ns
// Host end: APB slave registers drive packet sends on channel 0 and catch channel 3.
module hcpd_host
  import hcpd_pkg::*;
(
  // Clock, reset and enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link to the device.
  hcpd_if.host lnk
);

  logic [15:0] id_r;                     // Command identifier.
  logic [15:0] len_r;                    // Payload length.
  logic [63:0] pay_r;                    // Payload bytes, first byte lowest.
  logic busy_r;                          // Sending.
  logic [4:0] idx_r;                     // Byte being sent.
  logic [63:0] rsp_r;                    // Caught response bytes.
  logic [3:0] rcnt_r;                    // Response bytes caught.

  wire logic acc;
  wire logic wr;
  wire logic hit;
  wire logic [4:0] total;
  wire logic [7:0] cur;
  wire logic [31:0] rd;

  assign acc = psel && penable;
  assign wr = acc && pwrite;
  // Reads send the identifier alone; other commands send header and payload.
  assign total = (id_r[15:12] == 4'h1) ? 5'h2 : 5'(len_r[3:0]) + 5'(HDR_BYTES);
  assign cur = (idx_r == 5'h0) ? id_r[7:0] : (idx_r == 5'h1) ? id_r[15:8] :
               (idx_r == 5'h2) ? len_r[7:0] : (idx_r == 5'h3) ? len_r[15:8] :
               pay_r[8*3'(idx_r[2:0] - 3'h4) +: 8];
  assign lnk.ch0_data = cur;
  assign lnk.ch0_valid = busy_r;
  assign lnk.ch0_last = busy_r && (idx_r == total - 5'h1);
  assign lnk.ch3_ready = 1'b1;
  assign hit = paddr == REG_CTRL || paddr == REG_ID || paddr == REG_PAY0 || paddr == REG_PAY1 ||
               paddr == REG_LEN || paddr == REG_STAT || paddr == REG_RSP0 || paddr == REG_RSP1;
  assign rd = (paddr == REG_ID) ? {16'h0, id_r} : (paddr == REG_PAY0) ? pay_r[31:0] :
              (paddr == REG_PAY1) ? pay_r[63:32] : (paddr == REG_LEN) ? {16'h0, len_r} :
              (paddr == REG_STAT) ? {27'h0, rcnt_r, busy_r} : (paddr == REG_RSP0) ? rsp_r[31:0] :
              (paddr == REG_RSP1) ? rsp_r[63:32] : 32'h0;

  // Registers, sender and response catcher; APB answers in the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_r <= 16'h0;
      len_r <= 16'h0;
      pay_r <= 64'h0;
      busy_r <= 1'b0;
      idx_r <= 5'h0;
      rsp_r <= 64'h0;
      rcnt_r <= 4'h0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      prdata <= (psel && !penable && !pwrite) ? rd : 32'h0;
      if (wr && pready && !busy_r) begin
        case (paddr)
          REG_ID: id_r <= pwdata[15:0];
          REG_LEN: len_r <= pwdata[15:0];
          REG_PAY0: pay_r[31:0] <= pwdata;
          REG_PAY1: pay_r[63:32] <= pwdata;
          REG_CTRL: begin
            if (pwdata[0]) begin
              busy_r <= 1'b1;
              idx_r <= 5'h0;
              rcnt_r <= 4'h0;
            end
          end
          default: begin
          end
        endcase
      end
      if (busy_r && lnk.ch0_ready) begin
        if (lnk.ch0_last) begin
          busy_r <= 1'b0;
        end else begin
          idx_r <= idx_r + 5'h1;
        end
      end
      if (lnk.ch3_valid && rcnt_r < 4'h8) begin
        rsp_r[8*rcnt_r[2:0] +: 8] <= lnk.ch3_data;
        rcnt_r <= rcnt_r + 4'h1;
      end
    end
  end

endmodule

// *** test/hcpd_chk.sv ***
`timescale 1ns/1ns
// ****************************************
// Link checker: watches both channels of the host-device link.
// ****************************************
module hcpd_chk (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Channel 0, host to device.
  input wire logic [7:0] ch0_data,
  input wire logic ch0_valid,
  input wire logic ch0_last,
  input wire logic ch0_ready,
  // Channel 3, device to host.
  input wire logic [7:0] ch3_data,
  input wire logic ch3_valid,
  input wire logic ch3_last,
  input wire logic ch3_ready
);
  logic [1:0] idx_r;   // Byte position in the request, held at 2 past the id.
  logic [1:0] ridx_r;  // Byte position in the response.
  logic [7:0] lo_r;    // Low identifier byte of the request.
  logic [7:0] hi_r;    // High identifier byte of the request.
  wire hs0 = ch0_valid && ch0_ready;
  wire hs3 = ch3_valid && ch3_ready;
  wire [7:0] hi_now = (idx_r == 2'h1) ? ch0_data : hi_r;
  wire rd_end = hs0 && ch0_last && hi_now[7:4] == 4'h1;
  wire wr_end = hs0 && ch0_last && hi_now[7:4] == 4'h0;
  // Tracks byte positions so the identifier can be compared with the answer.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_r <= 2'h0;
      ridx_r <= 2'h0;
      lo_r <= 8'h00;
      hi_r <= 8'h00;
    end else begin
      idx_r <= !hs0 ? idx_r : (ch0_last ? 2'h0 : (idx_r[1] ? idx_r : idx_r + 2'h1));
      ridx_r <= !hs3 ? ridx_r : (ch3_last ? 2'h0 : ridx_r + 2'h1);
      lo_r <= (hs0 && idx_r == 2'h0) ? ch0_data : lo_r;
      hi_r <= (hs0 && idx_r == 2'h1) ? ch0_data : hi_r;
    end
  end
  a_exec_stall: assert property (@(posedge pclk) disable iff (!presetn) hs0 && ch0_last |=> !ch0_ready)
    else $error("channel 0 kept ready in the execute cycle");
  a_rd_answer: assert property (@(posedge pclk) disable iff (!presetn)
    rd_end |-> ##[1:3] (ch3_valid && ch3_data == lo_r))
    else $error("read request not answered with its number");
  a_rsp_num: assert property (@(posedge pclk) disable iff (!presetn)
    hs3 && ridx_r == 2'h1 |-> ch3_data == {4'h0, hi_r[3:0]})
    else $error("response id high byte wrong");
  a_rsp_len: assert property (@(posedge pclk) disable iff (!presetn) hs3 && ridx_r[1] |-> ch3_data == 8'h00)
    else $error("response length not zero");
  a_rsp_last: assert property (@(posedge pclk) disable iff (!presetn) hs3 |-> ch3_last == (ridx_r == 2'h3))
    else $error("response last flag misplaced");
  a_wr_silent: assert property (@(posedge pclk) disable iff (!presetn) wr_end |=> !ch3_valid [*4])
    else $error("write request produced a response");
  a_wr_ready: assert property (@(posedge pclk) disable iff (!presetn) wr_end |-> ##[1:4] ch0_ready)
    else $error("channel 0 not ready after a write");
  a_rsp_ready: assert property (@(posedge pclk) disable iff (!presetn) hs3 && ch3_last |-> ##[1:4] ch0_ready)
    else $error("channel 0 not ready after a response");
  a_ch0_hold: assert property (@(posedge pclk) disable iff (!presetn)
    ch0_valid && !ch0_ready |=> ch0_valid && $stable(ch0_data) && $stable(ch0_last))
    else $error("host changed an offered byte");
endmodule

// *** test/hcpd_bench.sv ***
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
// ****************************************
// Bench: drives the host end over APB, checks the device outputs.
// ****************************************
module hcpd_bench;
  import hcpd_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rv;
  logic pready, pslverr, ev, ts_delta_en, ts_full_en, cmd_done, cmd_reject, range_changed, pwr_valid;
  logic [NUM_PS*16-1:0] ps_range, snap;
  logic [NUM_PS*5-1:0] ps_scale;
  logic [2:0] pwr_group, pw_grp;
  logic [11:0] pwr_num, pw_num;
  int failures = 0, comparisons = 0, ev_cnt = 0, rej_cnt = 0, pw_cnt = 0, rc_cnt = 0, r0, p0;
  logic [15:0] rt [5][4] = '{'{0, 16'h10, 0, 16}, '{1, 16'h4, 0, 16}, '{1, 16'h40, 0, 64}, '{0, 0, 0, 64},
    '{4, 16'h100, 2, 256}};  // Sensor, request, physical sensor, expected range.
  logic [15:0] pt [13] = '{16'h0101, 16'h0104, 16'h0120, 16'h0160, 16'h0250, 16'h0333, 16'h0400, 16'h05aa,
    16'h0800, 16'h0dff, 16'h0e00, 16'h0eff, 16'h0f00};  // Parameter write ids.
  logic [2:0] pg [13] = '{1, 0, 0, 1, 2, 3, 0, 4, 5, 5, 6, 6, 0};  // Expected group, 0 means refused.
  always #25 pclk = ~pclk;
  hcpd_if lnk();
  hcpd_host hcpd_host_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk));
  hcpd_dev hcpd_dev_inst (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .lnk(lnk), .ts_delta_en(ts_delta_en),
    .ts_full_en(ts_full_en), .ps_range(ps_range), .ps_scale(ps_scale), .cmd_done(cmd_done), .cmd_reject(cmd_reject),
    .range_changed(range_changed), .pwr_valid(pwr_valid), .pwr_group(pwr_group), .pwr_num(pwr_num));
  hcpd_chk hcpd_chk_inst (.pclk(pclk), .presetn(presetn), .ch0_data(lnk.ch0_data), .ch0_valid(lnk.ch0_valid),
    .ch0_last(lnk.ch0_last), .ch0_ready(lnk.ch0_ready), .ch3_data(lnk.ch3_data), .ch3_valid(lnk.ch3_valid),
    .ch3_last(lnk.ch3_last), .ch3_ready(lnk.ch3_ready));
  // Counts the one-cycle outcome pulses and keeps the last handed-on write.
  always @(posedge pclk) begin
    if (cmd_done === 1'b1 || cmd_reject === 1'b1) ev_cnt <= ev_cnt + 1;
    if (cmd_reject === 1'b1) rej_cnt <= rej_cnt + 1;
    if (range_changed === 1'b1) rc_cnt <= rc_cnt + 1;
    if (pwr_valid === 1'b1) begin
      pw_cnt <= pw_cnt + 1;
      pw_grp <= pwr_group;
      pw_num <= pwr_num;
    end
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One APB transfer: setup, then access until pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      failures++;
      print_verdict();
    end
    r = prdata; e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  // Sends one packet through the host registers and waits for the outcome.
  task automatic send(input logic [15:0] id, input logic [15:0] len, input logic [31:0] pay0);
    int n, n0;
    n0 = ev_cnt; n = 0;
    apb(1'b1, REG_ID, {16'h0, id}, rv, ev);
    apb(1'b1, REG_LEN, {16'h0, len}, rv, ev);
    apb(1'b1, REG_PAY0, pay0, rv, ev);
    apb(1'b1, REG_PAY1, 32'ha5c3_9e71, rv, ev);
    apb(1'b1, REG_CTRL, 32'h1, rv, ev);
    do begin
      @(posedge pclk);
      n++;
    end while (ev_cnt == n0 && n < 300);
    do begin
      apb(1'b0, REG_STAT, 32'h0, rv, ev);
      n++;
    end while (rv[0] !== 1'b0 && n < 400);
    if (n >= 400 || ev_cnt == n0) begin
      failures++;
      print_verdict();
    end
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    `CHK({ts_delta_en, ts_full_en}, 2'b11)
    for (int p = 0; p < NUM_PS; p++) begin
      `CHK(ps_range[p*16 +: 16], RANGE_DEF)
      `CHK(ps_scale[p*5 +: 5], 5'h0c)
    end
    // Every flag value, with reserved bits and bytes set.
    for (int f = 3; f >= 0; f--) begin
      send(CMD_FMT, LEN_SHORT, {24'h5a5a5a, 6'h3f, 2'(f)});
      `CHK({ts_delta_en, ts_full_en}, {~f[0], ~f[1]})
    end
    // Shared sensor takes the largest nonzero request.
    foreach (rt[i]) begin
      r0 = rc_cnt;
      send(CMD_RANGE, LEN_SHORT, {8'h5a, rt[i][1], rt[i][0][7:0]});
      `CHK(rc_cnt - r0, 1)
      `CHK(ps_range[rt[i][2]*16 +: 16], rt[i][3])
      `CHK(ps_scale[rt[i][2]*5 +: 5], 5'(15 - $clog2(rt[i][3])))
    end
    // Fused outputs and unknown commands are refused without effect.
    snap = ps_range; r0 = rej_cnt; p0 = rc_cnt;
    send(CMD_RANGE, LEN_SHORT, 32'h00002006);
    send(16'h0002, LEN_SHORT, 32'h0);
    `CHK(rej_cnt - r0, 2)
    `CHK(ps_range, snap)
    `CHK(rc_cnt - p0, 0)
    // Parameter writes by group; read-only and reserved ones refused.
    foreach (pt[i]) begin
      r0 = rej_cnt; p0 = pw_cnt;
      send(pt[i], 16'h0, 32'h0);
      `CHK(rej_cnt - r0, (pg[i] == 0) ? 1 : 0)
      `CHK(pw_cnt - p0, (pg[i] == 0) ? 0 : 1)
      if (pg[i] != 0) `CHK({pw_grp, pw_num}, {pg[i], pt[i][11:0]})
    end
    `CHK({ts_delta_en, ts_full_en}, 2'b11)
    // A read of a read-only parameter is answered on channel 3.
    r0 = rej_cnt;
    send(16'h1104, 16'h0, 32'h0);
    `CHK(rej_cnt - r0, 0)
    apb(1'b0, REG_STAT, 32'h0, rv, ev);
    `CHK(rv[4:0], 5'h08)
    apb(1'b0, REG_RSP0, 32'h0, rv, ev);
    `CHK(rv, 32'h0000_0104)
    apb(1'b0, 8'h40, 32'h0, rv, ev);
    `CHK(ev, 1'b1)
    print_verdict();
  end
endmodule
